/* rtl/aoc_config_regs.sv */
/*
  output configuration register bank with its serial configuration port.
  a 16-bit word per access: read/write flag, 7-bit address, 8 data bits.
  assumes the serial pins are asynchronous to clk and toggle slowly
  enough (several clk periods per level) to be oversampled.
*/
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_config_regs (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cfg_sel_b,
  input  wire logic        cfg_sck,
  input  wire logic        cfg_sdi,
  output logic             cfg_sdo_o,
  output logic             cfg_sdo_oe,
  input  wire logic        enc_clk_in,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        sample_over,
  output logic             forwarded_output_clock,
  output logic [1:0]       out_clock_phase_delay,
  output logic             duty_cycle_stabilizer_on,
  output logic [2:0]       diff_driver_current,
  output logic             internal_termination_on,
  output logic             current_double,
  output aoc_pkg::aoc_format_type output_format_select,
  output logic             sleep_pulse,
  output logic [15:0]      data_out,
  output logic             overflow_output,
  output logic             data_out_en
);
  logic [1:0]  sel_sync_r;
  logic [2:0]  sck_sync_r;
  logic [1:0]  sdi_sync_r;
  logic [1:0]  enc_sync_r;
  aoc_pkg::aoc_state_type state_r;
  aoc_pkg::aoc_state_type state_nxt;
  logic [4:0]  count_r;
  logic [15:0] shift_r;
  logic [7:0]  rdata_r;
  logic        sdo_r;
  logic        sleep_r;
  logic [7:0]  timing_r;
  logic [7:0]  driver_r;
  logic [7:0]  format_r;
  logic        fwd_r;

  // the second stage of each synchroniser is read below, and the third sck stage for edge detection
  wire sel_b   = sel_sync_r[1];
  wire sck_s   = sck_sync_r[1];
  wire sck_rise = sck_s & ~sck_sync_r[2];
  wire sck_fall = ~sck_s & sck_sync_r[2];
  wire sel_act = ~sel_b;

  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] t,
                                          input logic [7:0] d, input logic [7:0] f);
    if (a == `AOC_ADDR_TIMING)      reg_read = t;
    else if (a == `AOC_ADDR_DRIVER) reg_read = d;
    else if (a == `AOC_ADDR_FORMAT) reg_read = f;
    else                            reg_read = `AOC_RESET_VAL;
  endfunction

  // frame decode, address in bits 14:8 after full word
  wire        word_done = (state_r == aoc_pkg::AOC_ST_SHIFT) && sck_rise && (count_r == `AOC_WORD_BITS - 5'h01);
  wire [15:0] word_w    = {shift_r[14:0], sdi_sync_r[1]};
  wire        wr_flag_n = ~word_w[15];
  wire [6:0]  word_addr = word_w[14:8];
  wire [7:0]  word_dat  = word_w[7:0];
  wire        do_write  = word_done & wr_flag_n;
  wire        wr_timing = do_write && (word_addr == `AOC_ADDR_TIMING);
  wire        wr_driver = do_write && (word_addr == `AOC_ADDR_DRIVER);
  wire        wr_format = do_write && (word_addr == `AOC_ADDR_FORMAT);
  wire        wr_swrst  = do_write && (word_addr == `AOC_ADDR_RESET) && word_dat[`AOC_SWRST_BIT];
  // read data loads once flag and address are in, ahead of the data bits
  wire        cmd_done  = (state_r == aoc_pkg::AOC_ST_SHIFT) && sck_rise && (count_r == `AOC_CMD_BITS - 5'h01);
  wire        rd_cmd    = cmd_done & shift_r[6];
  wire [6:0]  rd_addr   = word_w[6:0];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      aoc_pkg::AOC_ST_IDLE:  if (sel_act) state_nxt = aoc_pkg::AOC_ST_SHIFT;
      aoc_pkg::AOC_ST_SHIFT: begin
        if (!sel_act) state_nxt = aoc_pkg::AOC_ST_IDLE;
        else if (word_done) state_nxt = aoc_pkg::AOC_ST_DONE;
      end
      aoc_pkg::AOC_ST_DONE:  if (!sel_act) state_nxt = aoc_pkg::AOC_ST_IDLE; // extra edges ignored
      default:               state_nxt = aoc_pkg::AOC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_sync_r <= 2'h3;
      sck_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
      enc_sync_r <= 2'h0;
    end else begin
      sel_sync_r <= {sel_sync_r[0], cfg_sel_b};
      sck_sync_r <= {sck_sync_r[1:0], cfg_sck};
      sdi_sync_r <= {sdi_sync_r[0], cfg_sdi};
      enc_sync_r <= {enc_sync_r[0], enc_clk_in};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= aoc_pkg::AOC_ST_IDLE;
      count_r <= 5'h00;
      shift_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (state_r != aoc_pkg::AOC_ST_SHIFT) begin
        count_r <= 5'h00;
      end else if (sck_rise) begin
        count_r <= count_r + 5'h01;
        shift_r <= word_w;
      end
    end
  end

  // readback shifts out msb first on falling edges, open drain;
  // idle ones keep sdo released during write frames
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= `AOC_SDO_IDLE;
      sdo_r   <= 1'b1;
    end else begin
      if (!sel_act) begin
        rdata_r <= `AOC_SDO_IDLE;
        sdo_r   <= 1'b1;
      end else if (rd_cmd) begin
        rdata_r <= reg_read(rd_addr, timing_r, driver_r, format_r);
      end else if (sck_fall && state_r == aoc_pkg::AOC_ST_SHIFT && count_r >= `AOC_CMD_BITS) begin
        sdo_r   <= rdata_r[7];
        rdata_r <= {rdata_r[6:0], 1'b1};
      end
    end
  end

  // software reset has priority over a same-word register write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timing_r <= `AOC_RESET_VAL;
      driver_r <= `AOC_RESET_VAL;
      format_r <= `AOC_RESET_VAL;
      sleep_r  <= 1'b0;
    end else begin
      sleep_r <= wr_swrst;
      if (wr_swrst) begin
        timing_r <= `AOC_RESET_VAL;
        driver_r <= `AOC_RESET_VAL;
        format_r <= `AOC_RESET_VAL;
      end else begin
        if (wr_timing) timing_r <= word_dat;
        if (wr_driver) driver_r <= word_dat;
        if (wr_format) format_r <= word_dat;
      end
    end
  end

  // forwarded clock follows the encode clock; the fine phase delay itself
  // is analog and is only signalled out as a code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_r <= 1'b0;
    end else begin
      fwd_r <= enc_sync_r[1] ^ timing_r[`AOC_INV_BIT];
    end
  end

  // bits 7:4 of timing are never decoded
  assign forwarded_output_clock   = fwd_r;
  assign out_clock_phase_delay    = timing_r[`AOC_PH_HI:`AOC_PH_LO];
  assign duty_cycle_stabilizer_on = timing_r[`AOC_DCS_BIT];
  assign diff_driver_current      = driver_r[`AOC_CUR_HI:`AOC_CUR_LO];
  assign internal_termination_on  = driver_r[`AOC_TERM_BIT];
  assign current_double           = driver_r[`AOC_TERM_BIT];
  assign output_format_select     = aoc_pkg::aoc_format_type'(driver_r[`AOC_FMT_HI:`AOC_FMT_LO]);
  assign sleep_pulse              = sleep_r;
  assign cfg_sdo_o                = 1'b0;
  assign cfg_sdo_oe               = ~sdo_r;

  aoc_data_path u_data_path (
    .clk                    (clk),
    .rst_b                  (rst_b),
    .sample_valid           (sample_valid),
    .sample_data            (sample_data),
    .sample_over            (sample_over),
    .test_pattern_select    (format_r[`AOC_TP_HI:`AOC_TP_LO]),
    .alternate_bit_polarity (format_r[`AOC_ABP_BIT]),
    .output_randomizer_on   (format_r[`AOC_OUTPUT_RANDOMIZER_ON_BIT]),
    .twos_complement_coding (format_r[`AOC_TWOS_BIT]),
    .outputs_disable        (driver_r[`AOC_OFF_BIT]),
    .data_out               (data_out),
    .overflow_output        (overflow_output),
    .data_out_en            (data_out_en)
  );

  // register writes land one cycle after the sixteenth serial clock rise
  a_write_timing : assert property (@(posedge clk) disable iff (!rst_b)
    wr_timing && !wr_swrst
    |=> timing_r == $past(word_dat))
    else $error("timing register not written");

  a_write_driver : assert property (@(posedge clk) disable iff (!rst_b)
    wr_driver && !wr_swrst
    |=> driver_r == $past(word_dat))
    else $error("output mode register not written");

  a_write_format : assert property (@(posedge clk) disable iff (!rst_b)
    wr_format && !wr_swrst
    |=> format_r == $past(word_dat))
    else $error("data format register not written");

  a_read_keeps : assert property (@(posedge clk) disable iff (!rst_b)
    word_done && !wr_flag_n
    |=> $stable(timing_r) && $stable(driver_r) && $stable(format_r))
    else $error("read changed a register");

  a_unmapped_keep : assert property (@(posedge clk) disable iff (!rst_b)
    word_done && !wr_timing && !wr_driver && !wr_format && !wr_swrst
    |=> $stable(timing_r) && $stable(driver_r) && $stable(format_r))
    else $error("unmapped word changed a register");

  // a frame cut short by the select going high must write nothing
  a_abort_nowrite : assert property (@(posedge clk) disable iff (!rst_b)
    state_r == aoc_pkg::AOC_ST_SHIFT && !sel_act && !word_done
    |=> $stable(timing_r) && $stable(driver_r) && $stable(format_r))
    else $error("cut frame changed a register");

  a_done_ignore : assert property (@(posedge clk) disable iff (!rst_b)
    state_r == aoc_pkg::AOC_ST_DONE
    |=> $stable(timing_r) && $stable(driver_r) && $stable(format_r))
    else $error("extra serial clocks changed a register");

  a_sdo_release : assert property (@(posedge clk) disable iff (!rst_b)
    !sel_act
    |=> !cfg_sdo_oe)
    else $error("sdo pulled low outside a frame");

  a_swrst_clear : assert property (@(posedge clk) disable iff (!rst_b)
    wr_swrst
    |=> timing_r == `AOC_RESET_VAL && driver_r == `AOC_RESET_VAL && format_r == `AOC_RESET_VAL)
    else $error("software reset left a register set");

  a_sleep_pulse : assert property (@(posedge clk) disable iff (!rst_b)
    wr_swrst
    |=> sleep_pulse ##1 !sleep_pulse)
    else $error("sleep pulse not one cycle long");

  a_clk_invert : assert property (@(posedge clk) disable iff (!rst_b)
    $stable(timing_r)
    |=> fwd_r == ($past(enc_sync_r[1]) ^ $past(timing_r[`AOC_INV_BIT])))
    else $error("forwarded clock polarity wrong");

  a_phase_code : assert property (@(posedge clk) disable iff (!rst_b)
    wr_timing && !wr_swrst
    |=> out_clock_phase_delay == $past(word_dat[`AOC_PH_HI:`AOC_PH_LO]))
    else $error("phase delay code not taken");

  a_dcs_bit : assert property (@(posedge clk) disable iff (!rst_b)
    wr_timing && !wr_swrst
    |=> duty_cycle_stabilizer_on == $past(word_dat[`AOC_DCS_BIT]))
    else $error("stabilizer bit not taken");

  // a write that only touches bits 7:4 must leave every timing output alone
  a_upper_ignored : assert property (@(posedge clk) disable iff (!rst_b)
    wr_timing && !wr_swrst && word_dat[`AOC_INV_BIT:`AOC_DCS_BIT] == timing_r[`AOC_INV_BIT:`AOC_DCS_BIT]
    |=> $stable(out_clock_phase_delay) && $stable(duty_cycle_stabilizer_on) && $stable(timing_r[`AOC_INV_BIT]))
    else $error("unused timing bits had an effect");

  a_current_code : assert property (@(posedge clk) disable iff (!rst_b)
    wr_driver && !wr_swrst
    |=> diff_driver_current == $past(word_dat[`AOC_CUR_HI:`AOC_CUR_LO]))
    else $error("driver current code not taken");

  a_term_double : assert property (@(posedge clk) disable iff (!rst_b)
    wr_driver && !wr_swrst
    |=> internal_termination_on == $past(word_dat[`AOC_TERM_BIT]) && current_double == internal_termination_on)
    else $error("termination or current doubling wrong");

  a_format_code : assert property (@(posedge clk) disable iff (!rst_b)
    wr_driver && !wr_swrst
    |=> output_format_select == $past(word_dat[`AOC_FMT_HI:`AOC_FMT_LO]))
    else $error("output format code not taken");

  a_disable_out : assert property (@(posedge clk) disable iff (!rst_b)
    driver_r[`AOC_OFF_BIT] ##1 driver_r[`AOC_OFF_BIT]
    |-> !data_out_en)
    else $error("outputs driven while disabled");

  c_write : cover property (@(posedge clk) disable iff (!rst_b) wr_driver);
  c_read : cover property (@(posedge clk) disable iff (!rst_b) rd_cmd);
  c_swrst : cover property (@(posedge clk) disable iff (!rst_b) wr_swrst);
  c_abort : cover property (@(posedge clk) disable iff (!rst_b) state_r == aoc_pkg::AOC_ST_SHIFT && !sel_act);
endmodule

/* rtl/aoc_params.svh */
/*
  constants for the converter output configuration register bank:
  register addresses, field positions, codes and serial word layout.
  assumes inclusion by bare name from the design files.
*/
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH
`define AOC_ADDR_RESET      7'h00
`define AOC_ADDR_TIMING     7'h02
`define AOC_ADDR_DRIVER     7'h03
`define AOC_ADDR_FORMAT     7'h04
`define AOC_RESET_VAL       8'h00
`define AOC_SWRST_BIT       7
`define AOC_WORD_BITS       5'h10
`define AOC_CMD_BITS        5'h08
`define AOC_INV_BIT         3
`define AOC_PH_HI           2
`define AOC_PH_LO           1
`define AOC_DCS_BIT         0
`define AOC_CUR_HI          6
`define AOC_CUR_LO          4
`define AOC_TERM_BIT        3
`define AOC_OFF_BIT         2
`define AOC_FMT_HI          1
`define AOC_FMT_LO          0
`define AOC_TP_HI           5
`define AOC_TP_LO           3
`define AOC_ABP_BIT         2
`define AOC_OUTPUT_RANDOMIZER_ON_BIT        1
`define AOC_TWOS_BIT        0
`define AOC_TP_OFF          3'h0
`define AOC_TP_ZERO         3'h1
`define AOC_TP_ONE          3'h3
`define AOC_TP_CHECK        3'h5
`define AOC_TP_ALT          3'h7
`define AOC_CHECK_PAT       17'h15555
`define AOC_ALL_ONES        17'h1FFFF
`define AOC_ALL_ZERO        17'h00000
`define AOC_SIGN_BIT        16'h8000
`define AOC_ABP_MASK        16'hAAAA
`define AOC_SDO_IDLE        8'hFF
`endif

/* rtl/aoc_pkg.sv */
/*
  types for the output configuration register bank.
  assumes aoc_params.svh supplies the numeric constants.
*/
package aoc_pkg;
  typedef enum logic [1:0] {
    AOC_FMT_FULL_CMOS = 2'b00,
    AOC_FMT_DDR_DIFF  = 2'b01,
    AOC_FMT_DDR_CMOS  = 2'b10,
    AOC_FMT_UNUSED    = 2'b11
  } aoc_format_type;
  typedef enum logic [1:0] {
    AOC_ST_IDLE  = 2'b00,
    AOC_ST_SHIFT = 2'b01,
    AOC_ST_DONE  = 2'b10
  } aoc_state_type;
endpackage

/* rtl/aoc_data_path.sv */
/*
  output data path: coding, test patterns, randomizer, output enable.
  assumes sample_valid is a one-cycle strobe on clk per conversion result.
*/
`timescale 1ns/1ps
`include "aoc_params.svh"
module aoc_data_path (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        sample_over,
  input  wire logic [2:0]  test_pattern_select,
  input  wire logic        alternate_bit_polarity,
  input  wire logic        output_randomizer_on,
  input  wire logic        twos_complement_coding,
  input  wire logic        outputs_disable,
  output logic      [15:0] data_out,
  output logic             overflow_output,
  output logic             data_out_en
);
  logic        phase_r;
  logic [16:0] word_r;
  logic        en_r;
  wire         twos_eff   = twos_complement_coding & ~alternate_bit_polarity;
  wire  [15:0] coded      = twos_eff ? (sample_data ^ `AOC_SIGN_BIT) : sample_data;
  // randomizer: lsb xor into upper bits, reversible by the receiver
  wire  [15:0] output_randomizer_on_d     = {coded[15:1] ^ {15{coded[0]}}, coded[0]};
  wire  [15:0] rnd        = output_randomizer_on ? output_randomizer_on_d : coded;
  // alternate bit polarity inverts odd bits to cut supply coupling
  wire  [15:0] abp_d      = alternate_bit_polarity ? (rnd ^ `AOC_ABP_MASK) : rnd;
  wire  [16:0] conv_w     = {sample_over, abp_d};
  wire  [16:0] check_w    = phase_r ? ~`AOC_CHECK_PAT : `AOC_CHECK_PAT;
  wire  [16:0] alt_w      = phase_r ? `AOC_ALL_ONES : `AOC_ALL_ZERO;
  wire  [16:0] word_nxt   = (test_pattern_select == `AOC_TP_ZERO)  ? `AOC_ALL_ZERO :
                            (test_pattern_select == `AOC_TP_ONE)   ? `AOC_ALL_ONES :
                            (test_pattern_select == `AOC_TP_CHECK) ? check_w :
                            (test_pattern_select == `AOC_TP_ALT)   ? alt_w :
                            conv_w;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
      word_r  <= 17'h00000;
      en_r    <= 1'b0;
    end else begin
      en_r <= ~outputs_disable;
      if (sample_valid) begin
        phase_r <= ~phase_r;
        word_r  <= word_nxt;
      end
    end
  end
  assign data_out        = word_r[15:0];
  assign overflow_output = word_r[16];
  assign data_out_en     = en_r;
  a_check_alt : assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_CHECK |=> word_r == $past(check_w))
    else $error("checkerboard word wrong");
  // samples are spaced apart, so the flip is checked against the phase bit
  a_alt_flip : assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_ALT
    |=> (word_r == `AOC_ALL_ZERO || word_r == `AOC_ALL_ONES) && word_r[0] == $past(phase_r)
        && phase_r != $past(phase_r))
    else $error("alternating pattern did not flip");
  a_zero_pat : assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_ZERO |=> word_r == `AOC_ALL_ZERO)
    else $error("zero pattern wrong");
  a_abp_offset : assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_OFF && alternate_bit_polarity && !output_randomizer_on
    |=> data_out == ($past(sample_data) ^ `AOC_ABP_MASK))
    else $error("abp did not force offset binary");
  a_twos_code : assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_OFF && twos_complement_coding && !alternate_bit_polarity
    && !output_randomizer_on |=> data_out == ($past(sample_data) ^ `AOC_SIGN_BIT))
    else $error("twos complement coding wrong");
  a_out_off : assert property (@(posedge clk) disable iff (!rst_b)
    outputs_disable |=> !data_out_en)
    else $error("outputs still driven when disabled");
  c_check : cover property (@(posedge clk) disable iff (!rst_b)
    sample_valid && test_pattern_select == `AOC_TP_CHECK);
endmodule

/* tb/aoc_host_model.sv */
/*
  host model for the serial configuration port: 16-bit words, msb first.
  assumes a pull-up on sdo on the bench side and clk as its timing base.
*/
`timescale 1ns/1ps
module aoc_host_model (
  input  wire logic clk,
  output logic      cfg_sel_b,
  output logic      cfg_sck,
  output logic      cfg_sdi,
  input  wire logic cfg_sdo
);
  // six clk per sck level: the port's synchroniser needs at least three
  localparam int HALF = 6;
  initial begin
    cfg_sel_b = 1'b1;
    cfg_sck   = 1'b0;
    cfg_sdi   = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // fewer than 16 bits ends the frame early, which must abort it
  task automatic xfer(input logic [15:0] w, input int nbit, output logic [7:0] rd);
    rd = 8'h00;
    cfg_sel_b <= 1'b0;
    hold(HALF);
    for (int i = 15; i > 15 - nbit; i--) begin
      cfg_sdi <= w[i];
      hold(HALF);
      if (i < 8) begin
        rd[i] = cfg_sdo;
      end
      cfg_sck <= 1'b1;
      hold(HALF);
      cfg_sck <= 1'b0;
    end
    hold(HALF);
    cfg_sel_b <= 1'b1;
    // a released data line must not look like it still holds the last bit
    cfg_sdi   <= ~cfg_sdi;
    hold(HALF);
  endtask
endmodule

/* tb/adc_output_config_registers_tb_top.sv */
/*
  self-checking bench for the output configuration register bank.
  assumes the host model on the serial port and a pull-up on sdo.
*/
`timescale 1ns/1ps
`include "aoc_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adc_output_config_registers_tb_top;
  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    enc_clk_in = 1'b0;
  logic                    sample_valid = 1'b0;
  logic [15:0]             sample_data = 16'h0000;
  logic                    sample_over = 1'b0;
  logic                    sleep_seen = 1'b0;
  wire                     cfg_sel_b;
  wire                     cfg_sck;
  wire                     cfg_sdi;
  logic                    cfg_sdo_o;
  logic                    cfg_sdo_oe;
  logic                    forwarded_output_clock;
  logic [1:0]              out_clock_phase_delay;
  logic                    duty_cycle_stabilizer_on;
  logic [2:0]              diff_driver_current;
  logic                    internal_termination_on;
  logic                    current_double;
  aoc_pkg::aoc_format_type output_format_select;
  logic                    sleep_pulse;
  logic [15:0]             data_out;
  logic                    overflow_output;
  logic                    data_out_en;
  int                      fails = 0;
  int                      tests_run = 0;
  int                      cycles = 0;
  int                      nsmp = 0;
  logic [7:0]              rd;
  // open-drain sdo with its pull-up
  wire sdo_line = cfg_sdo_oe ? cfg_sdo_o : 1'b1;
  wire [10:0] cfg_view = {forwarded_output_clock, out_clock_phase_delay, duty_cycle_stabilizer_on,
                          diff_driver_current, internal_termination_on, output_format_select, data_out_en};
  aoc_host_model host (.clk, .cfg_sel_b, .cfg_sck, .cfg_sdi, .cfg_sdo(sdo_line));
  aoc_config_regs dut (.clk, .rst_b, .cfg_sel_b, .cfg_sck, .cfg_sdi, .cfg_sdo_o, .cfg_sdo_oe, .enc_clk_in,
    .sample_valid, .sample_data, .sample_over, .forwarded_output_clock, .out_clock_phase_delay,
    .duty_cycle_stabilizer_on, .diff_driver_current, .internal_termination_on, .current_double,
    .output_format_select, .sleep_pulse, .data_out, .overflow_output, .data_out_en);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (sleep_pulse === 1'b1) begin
      sleep_seen <= 1'b1;
    end
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    @(posedge clk);
    host.xfer({1'b0, a, d}, 16, x);
  endtask
  task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    host.xfer({1'b1, a, 8'h00}, 16, d);
  endtask
  task automatic smp(input logic [15:0] d, input logic ov, input logic [16:0] exp);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data  <= d;
    sample_over  <= ov;
    @(posedge clk);
    sample_valid <= 1'b0;
    nsmp++;
    @(posedge clk);
    #1;
    `CHK({overflow_output, data_out}, exp)
  endtask
  task automatic t_timing();
    for (int p = 0; p < 4; p++) begin
      wr(`AOC_ADDR_TIMING, {4'hF, p[0], p[1:0], 1'b1});
      enc_clk_in <= p[1];
      repeat (6) @(posedge clk);
      `CHK(cfg_view[10:7], {p[1] ^ p[0], p[1:0], 1'b1})
    end
    wr(`AOC_ADDR_TIMING, 8'hF0);
    `CHK(cfg_view[10:7], 4'b1000)
    wr(`AOC_ADDR_TIMING, 8'h50);
    `CHK(cfg_view[10:7], 4'b1000)
  endtask
  task automatic t_driver();
    logic [7:0] v;
    int f;
    for (int c = 0; c < 8; c++) begin
      f = c % 3;
      v = {1'b0, c[2:0], c[0], 1'b0, f[1:0]};
      if (c != 3) begin
        wr(`AOC_ADDR_DRIVER, v);
        `CHK({cfg_view[6:0], current_double}, {c[2:0], c[0], f[1:0], 2'b11 & {1'b1, c[0]}})
        rdreg(`AOC_ADDR_DRIVER, rd);
        `CHK(rd, v)
      end
    end
  endtask
  task automatic t_disable();
    wr(`AOC_ADDR_DRIVER, 8'h04);
    wr(7'h01, 8'h03);
    `CHK(data_out_en, 1'b0)
    wr(7'h01, 8'h00);
    wr(`AOC_ADDR_DRIVER, 8'h00);
    `CHK(data_out_en, 1'b1)
    rdreg(7'h05, rd);
    `CHK(rd, 8'h00)
  endtask
  task automatic t_format();
    wr(`AOC_ADDR_FORMAT, 8'h00);
    smp(16'h1234, 1'b0, 17'h01234);
    wr(`AOC_ADDR_FORMAT, 8'h01);
    smp(16'h1234, 1'b1, 17'h19234);
    wr(`AOC_ADDR_FORMAT, 8'h05);
    smp(16'h1234, 1'b0, 17'h0B89E);
    wr(`AOC_ADDR_FORMAT, 8'h02);
    smp(16'h1235, 1'b0, 17'h0EDCB);
    wr(`AOC_ADDR_FORMAT, 8'h08);
    smp(16'h1234, 1'b1, `AOC_ALL_ZERO);
    wr(`AOC_ADDR_FORMAT, 8'h18);
    smp(16'h1234, 1'b0, `AOC_ALL_ONES);
    wr(`AOC_ADDR_FORMAT, 8'h28);
    repeat (2) smp(16'h1234, 1'b0, nsmp[0] ? 17'h0AAAA : `AOC_CHECK_PAT);
    wr(`AOC_ADDR_FORMAT, 8'h38);
    repeat (2) smp(16'h1234, 1'b0, nsmp[0] ? `AOC_ALL_ONES : `AOC_ALL_ZERO);
  endtask
  task automatic t_abort();
    @(posedge clk);
    host.xfer({1'b0, `AOC_ADDR_DRIVER, 8'h52}, 12, rd);
    `CHK(diff_driver_current, 3'b000)
    rdreg(`AOC_ADDR_TIMING, rd);
    `CHK(rd, 8'h50)
  endtask
  task automatic t_swreset();
    wr(`AOC_ADDR_TIMING, 8'h07);
    wr(`AOC_ADDR_DRIVER, 8'h49);
    wr(`AOC_ADDR_FORMAT, 8'h2B);
    sleep_seen <= 1'b0;
    wr(`AOC_ADDR_RESET, 8'h80);
    `CHK(sleep_seen, 1'b1)
    `CHK(cfg_view[9:0], 10'h001)
    rdreg(`AOC_ADDR_FORMAT, rd);
    `CHK(rd, 8'h00)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK(cfg_view, 11'h001)
    t_timing();
    t_driver();
    t_disable();
    t_format();
    t_abort();
    t_swreset();
    end_sim();
  end
endmodule
